/* logic/wmc_compressor.v */
// Waveform min/max compressor with display offset adder and register port.
// Assumes the sample source and display sink use valid/ready on clk.
//
// Behaviour
// - compressed mode delivers 512 output pairs for each complete display record.
// - pass-through mode forwards every input sample unchanged, once, through the minimum adder only.
// - compressed mode splits input into groups of group_size_factor samples.
// - one minimum/maximum pair is produced per group, 512 per display record.
// - programmed display offset is applied to every output pair value.
// - adder adds signed offset; a negative offset shifts data downward.
// - with vectoring, min and max holding registers swap roles between groups.
// - vectoring: previous min above new max becomes the new maximum.
// - vectoring: previous max below new min becomes the new minimum.
// - min loads on valid sample over over-range, empty register, or under-range sample.
// - min loads an in-range sample below the stored minimum.
// - min loads at group end when all empty, or when extremes undefined.
// - max loads by the mirrored criteria of the minimum register.
// - adder yields empty, under-range, over-range markers or the plain sum.
// - compressed mode always sends minimum first, then maximum.
// - group_size_factor of zero acts as a group of 256 samples.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`include "wmc_consts.vh"

module wmc_compressor (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Register port
	input  wire [4:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Sample stream from the memory manager
	input  wire        in_valid,
	output wire        in_ready,
	input  wire [15:0] in_data,
	// Value stream to the display sink
	output wire        out_valid,
	input  wire        out_ready,
	output reg  [15:0] out_data
);

	// One-hot states
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_MIN  = 3'h2;
	localparam [2:0] ST_LAST = 3'h4;

	// Software-visible control
	reg  [1:0]  mode_q;
	reg  [7:0]  factor_q;
	reg  [15:0] offset_q;
	reg         restart;

	// Sequencing state
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [8:0]  remain_q;
	reg  [9:0]  pairs_q;
	reg         done_q;

	// Holding registers and flags
	reg  [15:0] x_q;
	reg  [15:0] y_q;
	reg         min_is_y_q;
	reg         undef_q;
	reg         all_empty_q;
	reg  [15:0] pend_q;

	// Decoded sample conditions
	wire        compress;
	wire        vector_on;
	wire        accept;
	wire        send;
	wire        eoc;
	wire [8:0]  group_len;
	wire [15:0] cur_min;
	wire [15:0] cur_max;
	wire        d_empty;
	wire        d_under;
	wire        d_over;
	wire        d_plain;
	wire        group_all_empty_flag;
	wire        min_over;
	wire        min_under;
	wire        min_empty;
	wire        max_over;
	wire        max_under;
	wire        max_empty;
	reg         load_min;
	reg         load_max;
	wire [15:0] min_nxt;
	wire [15:0] max_nxt;
	wire        pair_out;

	// Adder paths
	wire [15:0] add_off;
	wire [15:0] add_a_in;
	wire [15:0] add_a_out;
	wire [15:0] add_b_out;

	assign compress  = mode_q[`WMC_MODE_COMPRESS];
	assign vector_on = mode_q[`WMC_MODE_VECTOR];

	// Register writes and restart decode
	always @* begin
		restart = 1'b0;
		if (reg_wr) begin
			if (reg_addr == `WMC_REG_MODE) begin
				restart = 1'b1;
			end else if (reg_addr == `WMC_REG_RESET) begin
				restart = 1'b1;
			end
		end
	end

	// Status is read only; writes there or to unmapped offsets are ignored
	always @(posedge clk) begin
		if (!rst_n) begin
			mode_q   <= `WMC_MODE_RST;
			factor_q <= `WMC_FACTOR_RST;
			offset_q <= `WMC_OFFSET_RST;
		end else if (reg_wr) begin
			if (reg_addr == `WMC_REG_MODE) begin
				mode_q <= reg_wdata[1:0];
			end else if (reg_addr == `WMC_REG_FACTOR) begin
				factor_q <= reg_wdata[7:0];
			end else if (reg_addr == `WMC_REG_OFFSET) begin
				offset_q <= reg_wdata[15:0];
			end
		end
	end

	// Register reads, answered one cycle later
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			if (reg_addr == `WMC_REG_MODE) begin
				reg_rdata <= {30'h0, mode_q};
			end else if (reg_addr == `WMC_REG_STATUS) begin
				reg_rdata <= {16'h0, all_empty_q, undef_q, state_q, done_q, pairs_q};
			end else if (reg_addr == `WMC_REG_FACTOR) begin
				reg_rdata <= {24'h0, factor_q};
			end else if (reg_addr == `WMC_REG_OFFSET) begin
				reg_rdata <= {16'h0, offset_q};
			end else begin
				reg_rdata <= 32'h0;
			end
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// Stream handshakes
	// A restart write closes the input so no sample joins a stale group
	assign in_ready  = state_q[0] & ~restart;
	assign accept    = in_valid & in_ready;
	assign out_valid = ~state_q[0];
	assign send      = out_valid & out_ready;

	// Group length and end of group
	assign group_len = (factor_q == 8'h00) ? `WMC_GROUP_ZERO : {1'b0, factor_q};
	assign eoc       = (remain_q == 9'h001);

	// Sample classification
	// Reserved codes never enter a magnitude comparison
	assign d_empty = (in_data == `WMC_EMPTY_MARK);
	assign d_under = (in_data == `WMC_UNDER_MARK);
	assign d_over  = (in_data == `WMC_OVER_MARK);
	assign d_plain = ~d_empty & ~d_under & ~d_over;
	assign group_all_empty_flag = all_empty_q & d_empty;

	// Role of each holding register
	assign cur_min = min_is_y_q ? y_q : x_q;
	assign cur_max = min_is_y_q ? x_q : y_q;

	assign min_over  = (cur_min == `WMC_OVER_MARK);
	assign min_under = (cur_min == `WMC_UNDER_MARK);
	assign min_empty = (cur_min == `WMC_EMPTY_MARK);
	assign max_over  = (cur_max == `WMC_OVER_MARK);
	assign max_under = (cur_max == `WMC_UNDER_MARK);
	assign max_empty = (cur_max == `WMC_EMPTY_MARK);

	// Minimum replacement
	always @* begin
		load_min = 1'b0;
		if (!d_empty && min_over) begin
			load_min = 1'b1;
		end else if (min_empty || d_under) begin
			load_min = 1'b1;
		end else if (!min_under && d_plain && ($signed(cur_min) > $signed(in_data))) begin
			load_min = 1'b1;
		end else if ((eoc && group_all_empty_flag) || undef_q) begin
			load_min = 1'b1;
		end
	end

	// Maximum replacement
	always @* begin
		load_max = 1'b0;
		if (!d_empty && max_under) begin
			load_max = 1'b1;
		end else if (max_empty || d_over) begin
			load_max = 1'b1;
		end else if (!max_over && d_plain && ($signed(cur_max) < $signed(in_data))) begin
			load_max = 1'b1;
		end else if ((eoc && group_all_empty_flag) || undef_q) begin
			load_max = 1'b1;
		end
	end

	assign min_nxt = load_min ? in_data : cur_min;
	assign max_nxt = load_max ? in_data : cur_max;

	// Offset is bypassed in pass-through so samples leave unchanged
	assign add_off  = compress ? offset_q : 16'h0000;
	assign add_a_in = compress ? min_nxt : in_data;

	wmc_offset_adder u_add_min (
		.value  (add_a_in),
		.offset (add_off),
		.result (add_a_out)
	);

	wmc_offset_adder u_add_max (
		.value  (max_nxt),
		.offset (add_off),
		.result (add_b_out)
	);

	// Sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept && !compress) begin
					state_d = ST_LAST;
				end else if (accept && eoc) begin
					state_d = ST_MIN;
				end
			end
			ST_MIN: begin
				if (send) begin
					state_d = ST_LAST;
				end
			end
			ST_LAST: begin
				if (send) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// A restart drops any pending output and returns to idle
	always @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else if (restart) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Group counter, holding registers and flags
	// Roles swap at every group end; without vectoring the extremes are also marked undefined
	always @(posedge clk) begin
		if (!rst_n) begin
			remain_q    <= 9'h001;
			x_q         <= `WMC_EMPTY_MARK;
			y_q         <= `WMC_EMPTY_MARK;
			min_is_y_q  <= 1'b0;
			undef_q     <= 1'b1;
			all_empty_q <= 1'b1;
		end else if (restart) begin
			remain_q    <= group_len;
			x_q         <= `WMC_EMPTY_MARK;
			y_q         <= `WMC_EMPTY_MARK;
			min_is_y_q  <= 1'b0;
			undef_q     <= 1'b1;
			all_empty_q <= 1'b1;
		end else if (accept && compress) begin
			if (min_is_y_q) begin
				y_q <= min_nxt;
				x_q <= max_nxt;
			end else begin
				x_q <= min_nxt;
				y_q <= max_nxt;
			end
			if (eoc) begin
				remain_q    <= group_len;
				min_is_y_q  <= ~min_is_y_q;
				undef_q     <= ~vector_on;
				all_empty_q <= 1'b1;
			end else begin
				remain_q    <= remain_q - 9'h001;
				undef_q     <= 1'b0;
				all_empty_q <= group_all_empty_flag;
			end
		end
	end

	// Output data, minimum first then maximum
	always @(posedge clk) begin
		if (!rst_n) begin
			out_data <= 16'h0000;
			pend_q   <= 16'h0000;
		end else if (accept && (!compress || eoc)) begin
			out_data <= add_a_out;
			pend_q   <= add_b_out;
		end else if (send && state_q[1]) begin
			out_data <= pend_q;
		end
	end

	// Pair count per display record
	// Restart clears the count; a record completing in that same cycle still reports done
	assign pair_out = send & state_q[2] & compress;

	always @(posedge clk) begin
		if (!rst_n) begin
			pairs_q <= 10'h000;
			done_q  <= 1'b0;
		end else if (pair_out && (pairs_q == `WMC_RECORD_PAIRS - 10'h001)) begin
			pairs_q <= 10'h000;
			done_q  <= 1'b1;
		end else if (restart) begin
			pairs_q <= 10'h000;
			done_q  <= 1'b0;
		end else if (pair_out) begin
			pairs_q <= pairs_q + 10'h001;
		end
	end

endmodule

/* inc/wmc_consts.vh */
// Constants for the waveform min/max compressor and offset adder.
// Assumes 16-bit two's complement samples and a 5-bit word-aligned register bus.
`ifndef WMC_CONSTS_VH
`define WMC_CONSTS_VH

// Sample width and reserved sample codes
`define WMC_DW            16
`define WMC_EMPTY_MARK    16'h8000
`define WMC_UNDER_MARK    16'h8001
`define WMC_OVER_MARK     16'h7fff

// Display record and group sizing
`define WMC_RECORD_PAIRS  10'h200
`define WMC_GROUP_ZERO    9'h100

// Register byte offsets
`define WMC_REG_MODE      5'h00
`define WMC_REG_STATUS    5'h04
`define WMC_REG_FACTOR    5'h08
`define WMC_REG_OFFSET    5'h0c
`define WMC_REG_RESET     5'h10

// Mode register fields
`define WMC_MODE_COMPRESS 0
`define WMC_MODE_VECTOR   1
`define WMC_MODE_RST      2'h1

// Reset values
`define WMC_FACTOR_RST    8'h01
`define WMC_OFFSET_RST    16'h0000

// Status register fields
`define WMC_ST_PAIRS_LO   0
`define WMC_ST_PAIRS_HI   9
`define WMC_ST_DONE       10
`define WMC_ST_STATE_LO   11
`define WMC_ST_STATE_HI   13
`define WMC_ST_UNDEF      14
`define WMC_ST_EMPTY      15

`endif

/* logic/wmc_offset_adder.v */
// Offset adder: shifts one sample by a signed offset with saturation markers.
// Assumes the caller registers the result; purely combinational.
`include "wmc_consts.vh"

module wmc_offset_adder (
	// Operands
	input  wire [15:0] value,
	input  wire [15:0] offset,
	// Result
	output reg  [15:0] result
);

	wire [15:0] sum;
	wire        neg_ovf;
	wire        pos_ovf;

	assign sum     = value + offset;
	assign neg_ovf = value[15] & offset[15] & ~sum[15];
	assign pos_ovf = ~value[15] & ~offset[15] & sum[15];

	always @* begin
		if (value == `WMC_EMPTY_MARK) begin
			result = `WMC_EMPTY_MARK;
		end else if (value == `WMC_UNDER_MARK || neg_ovf) begin
			result = `WMC_UNDER_MARK;
		end else if (value == `WMC_OVER_MARK || pos_ovf) begin
			result = `WMC_OVER_MARK;
		end else begin
			result = sum;
		end
	end

endmodule

/* bench/wmc_compressor_asserts.sv */
// Port checker for the compressor: handshakes, pair order, pass-through.
// Assumes it is bound to wmc_compressor and sees only its ports.
module wmc_checker (
	// Clock and reset
	input wire        clk,
	input wire        rst_n,
	// Register writes
	input wire [4:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	// Streams
	input wire        in_valid,
	input wire        in_ready,
	input wire [15:0] in_data,
	input wire        out_valid,
	input wire        out_ready,
	input wire [15:0] out_data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic        comp_q;
	logic        half_q;
	logic [15:0] first_q;
	wire         restart = reg_wr && (reg_addr == 5'h00 || reg_addr == 5'h10);
	wire         tk_in   = in_valid && in_ready;
	wire         tk_out  = out_valid && out_ready;
	// Mode and position within a pair
	always @(posedge clk) begin
		if (!rst_n) begin
			comp_q <= 1'h1;
			half_q <= 1'h0;
		end else begin
			if (reg_wr && reg_addr == 5'h00)
				comp_q <= reg_wdata[0];
			if (restart)
				half_q <= 1'h0;
			else if (tk_out && comp_q)
				half_q <= !half_q;
		end
		if (tk_out)
			first_q <= out_data;
	end
	property p_hold;
		out_valid && !out_ready && !restart |=> out_valid && $stable(out_data);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved before accept");
	property p_busy;
		out_valid |-> !in_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("input open while output waits");
	property p_idle;
		!out_valid && !restart |-> in_ready;
	endproperty
	a_idle: assert property (p_idle) else $error("input closed while idle");
	property p_rise;
		$rose(out_valid) |-> $past(tk_in);
	endproperty
	a_rise: assert property (p_rise) else $error("output without input");
	property p_pass;
		tk_in && !comp_q |=> out_valid && out_data == $past(in_data);
	endproperty
	a_pass: assert property (p_pass) else $error("pass-through altered sample");
	property p_single;
		tk_out && !comp_q && !restart |=> !out_valid;
	endproperty
	a_single: assert property (p_single) else $error("extra pass-through output");
	property p_first;
		tk_out && comp_q && !half_q && !restart |=> out_valid;
	endproperty
	a_first: assert property (p_first) else $error("maximum missing after minimum");
	property p_end;
		tk_out && comp_q && half_q |=> !out_valid;
	endproperty
	a_end: assert property (p_end) else $error("more than a pair per group");
	property p_order;
		tk_out && comp_q && half_q |-> $signed(out_data) >= $signed(first_q);
	endproperty
	a_order: assert property (p_order) else $error("maximum below minimum");
	c_pair: cover property (tk_out && comp_q && half_q);
	c_pass: cover property (tk_in && !comp_q);
	c_stall: cover property (out_valid && !out_ready);
endmodule
bind wmc_compressor wmc_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data);

/* bench/wmc_display_model.sv */
// Display sink model: accepts output values, optionally stalling.
// Assumes the bench reads got and n by hierarchical reference.
module wmc_display_model (
	// Clock and reset
	input  logic        clk,
	input  logic        rst_n,
	// Stall control
	input  logic        slow,
	// Value stream
	input  logic        out_valid,
	input  logic [15:0] out_data,
	output logic        out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] got [0:2047];
	int          n     = 0;
	logic [1:0]  cnt_q = '0;
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		if (!rst_n)
			out_ready <= 1'h0;
		else
			out_ready <= !slow || cnt_q == 2'h3;
		if (rst_n && out_valid && out_ready) begin
			got[n] <= out_data;
			n <= n + 1;
		end
	end
endmodule

/* bench/wmc_compressor_bench.sv */
// Self-checking bench for the compressor: registers, pairs, markers, record.
// Assumes the display model sits on the output stream; the bench feeds samples.
module wmc_compressor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk         = 1'h0;
	logic        rst_n       = 1'h0;
	logic        reg_wr      = 1'h0;
	logic        reg_rd      = 1'h0;
	logic        in_valid    = 1'h0;
	logic        slow        = 1'h0;
	logic [4:0]  reg_addr    = '0;
	logic [31:0] reg_wdata   = '0;
	logic [15:0] in_data     = '0;
	wire  [31:0] reg_rdata;
	wire         in_ready;
	wire         out_valid;
	wire         out_ready;
	wire  [15:0] out_data;
	int          failures    = 0;
	int          comparisons = 0;
	int          rd_i        = 0;
	always #50 clk = ~clk;
	wmc_compressor dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_data);
	wmc_display_model far (.clk, .rst_n, .slow, .out_valid, .out_data, .out_ready);
	task automatic end_sim;
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmp(input string what, input [31:0] exp, input [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input [4:0] a, input [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input [4:0] a, input [31:0] exp, input [31:0] mask);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		cmp("reg_rdata", exp, reg_rdata & mask);
		@(posedge clk);
		#1;
		cmp("reg_rdata idle", 32'h0, reg_rdata);
	endtask
	task automatic put(input [15:0] d);
		@(posedge clk);
		in_valid <= 1'h1;
		in_data <= d;
		do @(negedge clk); while (in_ready !== 1'h1);
		@(posedge clk);
		in_valid <= 1'h0;
		in_data <= ~d;
	endtask
	task automatic chk(input [15:0] e);
		while (far.n <= rd_i)
			@(negedge clk);
		cmp("out_data", {16'h0, e}, {16'h0, far.got[rd_i]});
		rd_i++;
	endtask
	task automatic grp(input int n, input [15:0] a, b, c, mn, mx);
		put(a);
		if (n > 1)
			put(b);
		if (n > 2)
			put(c);
		chk(mn);
		chk(mx);
	endtask
	initial begin
		#5ms;
		failures++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rd(5'h04, 32'hc800, 32'hffff_ffff);
		rd(5'h00, 32'h1, 32'hffff_ffff);
		rd(5'h08, 32'h1, 32'hffff_ffff);
		rd(5'h0c, 32'h0, 32'hffff_ffff);
		rd(5'h14, 32'h0, 32'hffff_ffff);
		wr(5'h08, 32'h2);
		wr(5'h0c, 32'hfffd);
		wr(5'h00, 32'h1);
		grp(2, 16'h000a, 16'h0014, 16'h0, 16'h0007, 16'h0011);
		slow <= 1'h1;
		grp(2, 16'h0014, 16'h000a, 16'h0, 16'h0007, 16'h0011);
		rd(5'h04, 32'h2, 32'h7ff);
		wr(5'h0c, 32'h0);
		wr(5'h00, 32'h3);
		grp(2, 16'h000a, 16'h0014, 16'h0, 16'h000a, 16'h0014);
		grp(2, 16'h001e, 16'h0028, 16'h0, 16'h0014, 16'h0028);
		grp(2, 16'h0005, 16'h0008, 16'h0, 16'h0005, 16'h0014);
		wr(5'h08, 32'h3);
		wr(5'h00, 32'h1);
		grp(3, 16'h8000, 16'h0032, 16'h8001, 16'h8001, 16'h0032);
		grp(3, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000);
		grp(3, 16'h0003, 16'h7fff, 16'h8000, 16'h0003, 16'h7fff);
		wr(5'h08, 32'h1);
		wr(5'h0c, 32'h7000);
		wr(5'h00, 32'h1);
		grp(1, 16'h7000, 16'h0, 16'h0, 16'h7fff, 16'h7fff);
		wr(5'h0c, 32'h9000);
		grp(1, 16'h9000, 16'h0, 16'h0, 16'h8001, 16'h8001);
		wr(5'h0c, 32'h5);
		wr(5'h00, 32'h0);
		put(16'h1234);
		chk(16'h1234);
		wr(5'h08, 32'h2);
		wr(5'h00, 32'h1);
		put(16'h0005);
		wr(5'h10, 32'h0);
		grp(2, 16'h0020, 16'h0030, 16'h0, 16'h0025, 16'h0035);
		rd(5'h04, 32'h1, 32'h7ff);
		wr(5'h08, 32'h0);
		wr(5'h0c, 32'h0);
		wr(5'h00, 32'h1);
		for (int i = 1; i <= 256; i++)
			put(16'(i));
		chk(16'h0001);
		chk(16'h0100);
		wr(5'h08, 32'h1);
		wr(5'h00, 32'h1);
		repeat (511) put(16'h0);
		rd_i += 1021;
		chk(16'h0);
		rd(5'h04, 32'h1ff, 32'h7ff);
		put(16'h0);
		rd_i += 1;
		chk(16'h0);
		rd(5'h04, 32'h400, 32'h400);
		end_sim;
	end
endmodule
